// File: hw/tws_pkg.sv
package tws_pkg;

   // fixed upper part of the 7-bit slave address
   localparam logic [3:0] ADDR_UPPER   = 4'h9;
   // high-speed master code prefix, low three bits free
   localparam logic [4:0] HS_CODE      = 5'h01;
   // pointer value after reset selects the temperature result
   localparam logic [2:0] PTR_RESET    = 3'h0;
   localparam logic [15:0] WORD_RESET  = 16'h0000;
   localparam logic [3:0] BITS_BYTE    = 4'h8;

   // bus timeout figure and its cycle count at the core clock rate
   localparam int unsigned REF_CLK_HZ  = 10000000;
   localparam int unsigned TIMEOUT_MS  = 22;
   localparam int unsigned TIMEOUT_CYC = (TIMEOUT_MS * REF_CLK_HZ) / 1000;

   // link-side sequencer states
   typedef enum logic [2:0] {
      TWS_IDLE = 3'b000,
      TWS_RECV = 3'b001,
      TWS_ACK  = 3'b010,
      TWS_SEND = 3'b011,
      TWS_MACK = 3'b100
   } tws_state_t;

   // kind of the byte being received
   typedef enum logic [1:0] {
      TWS_K_ADDR = 2'b00,
      TWS_K_PTR  = 2'b01,
      TWS_K_DATA = 2'b10
   } tws_kind_t;

   // one received data byte headed for the register set
   typedef struct packed {
      logic [2:0] ptr;
      logic       msb_byte;
      logic [7:0] data;
   } tws_wr_t;

endpackage

// File: hw/tws_slave.sv
`timescale 1ns/1ps
// Overview of operation
// (R1) first byte after write address is pointer
// (R2) read returns register chosen by stored pointer
// (R3) master changes pointer with pointer-only write
// (R4) reads leave stored pointer unchanged
// (R5) multi-byte contents travel high byte first
// (R6) own address with write bit acknowledged
// (R7) pointer and data bytes acknowledged, data written
// (R8) single data byte updates only high byte
// (R9) own address with read bit: send high, low
// (R10) master nack, start or stop ends read
// (R11) master leaves data high to end read
// (R12) master sends code byte for high speed
// (R13) high-speed code byte is never acknowledged
// (R14) code byte switches filtering to high speed
// (R15) stop returns filtering to fast mode
// (R16) line low 22 ms inside frame resets interface
// (R17) after timeout release data, await start
// (R18) master keeps clock at 1 kHz or more
// (R19) byte count unbounded, frame ends start/stop
// (R20) acknowledger holds data low in ninth pulse
// (R21) address 1001 plus pins latched at start
// (R22) low three pointer bits select register
// (R23) every completed read access is signalled
// (R24) bits shift most significant first
// (R25) foreign address left unanswered until start
module tws_slave #(
   parameter int unsigned TIMEOUT_CYCLES = tws_pkg::TIMEOUT_CYC
) (
   input  wire logic             ref_clk,
   input  wire logic             reset_n,
   input  wire logic             link_clk,
   input  wire logic             scl_in,
   input  wire logic             sda_in,
   output logic                  sda_out,
   output logic                  sda_oe,
   input  wire logic             addr_pin_bit0,
   input  wire logic             addr_pin_bit1,
   input  wire logic             addr_pin_bit2,
   output logic [2:0]            pointer_sel,
   input  wire logic [15:0]      reg_rd_data,
   output logic                  wr_valid,
   output tws_pkg::tws_wr_t      wr_evt,
   output logic                  rd_access,
   output logic                  hs_mode,
   output logic                  bus_timeout
);

   // ---------------- link domain ----------------
   logic [1:0]          lrst_sync_r;
   logic                lrst_n;
   logic [2:0]          scl_s_r;
   logic [2:0]          sda_s_r;
   logic [1:0]          pin0_s_r;
   logic [1:0]          pin1_s_r;
   logic [1:0]          pin2_s_r;
   logic                scl_rise;
   logic                scl_fall;
   logic                start_det;
   logic                stop_det;
   tws_pkg::tws_state_t state_r;
   tws_pkg::tws_kind_t  kind_r;
   logic [7:0]          rx_r;
   logic [7:0]          tx_r;
   logic [3:0]          cnt_r;
   logic [2:0]          own_lo_r;
   logic                rw_r;
   logic                acked_r;
   logic                msb_next_r;
   logic                nack_r;
   logic                reading_r;
   logic                in_frame_r;
   logic                hs_l_r;
   logic [2:0]          ptr_l_r;
   logic                ptr_tgl_r;
   tws_pkg::tws_wr_t    wr_l_r;
   logic                wr_tgl_r;
   logic                rd_tgl_r;
   logic [15:0]         word_l_r;
   logic                snap_ack_r;
   logic [1:0]          snap_req_s_r;
   logic [2:0]          to_s_r;
   logic                to_hit;
   logic                own_match;
   logic                snap_req_r;
   logic [15:0]         snap_r;
   logic                bus_to_tgl_r;

   // reset brought into the link domain
   always_ff @(posedge link_clk) begin
      lrst_sync_r <= {lrst_sync_r[0], reset_n};
   end
   assign lrst_n = lrst_sync_r[1];

   // pin and toggle synchronisers; third stage only for edge detection
   always_ff @(posedge link_clk) begin
      scl_s_r  <= {scl_s_r[1:0], scl_in};
      sda_s_r  <= {sda_s_r[1:0], sda_in};
      pin0_s_r <= {pin0_s_r[0], addr_pin_bit0};
      pin1_s_r <= {pin1_s_r[0], addr_pin_bit1};
      pin2_s_r <= {pin2_s_r[0], addr_pin_bit2};
      to_s_r   <= {to_s_r[1:0], bus_to_tgl_r};
      snap_req_s_r <= {snap_req_s_r[0], snap_req_r};
   end

   // bus conditions from synchronised lines
   assign scl_rise  = scl_s_r[1] & ~scl_s_r[2];
   assign scl_fall  = ~scl_s_r[1] & scl_s_r[2];
   assign start_det = scl_s_r[1] & scl_s_r[2] & sda_s_r[2] & ~sda_s_r[1];
   assign stop_det  = scl_s_r[1] & scl_s_r[2] & ~sda_s_r[2] & sda_s_r[1];
   assign to_hit    = to_s_r[2] ^ to_s_r[1];
   // (R21) own address check
   assign own_match = (rx_r[7:1] == {tws_pkg::ADDR_UPPER, own_lo_r});

   // read word mailbox: refreshed only between reads, so both bytes match
   always_ff @(posedge link_clk) begin
      if (!lrst_n) begin
         word_l_r   <= tws_pkg::WORD_RESET;
         snap_ack_r <= 1'b0;
      end else if (snap_req_s_r[1] != snap_ack_r && !reading_r) begin
         word_l_r   <= snap_r;
         snap_ack_r <= snap_req_s_r[1];
      end
   end

   // byte sequencer
   always_ff @(posedge link_clk) begin
      if (!lrst_n) begin
         state_r    <= tws_pkg::TWS_IDLE;
         kind_r     <= tws_pkg::TWS_K_ADDR;
         rx_r       <= 8'h00;
         tx_r       <= 8'h00;
         cnt_r      <= 4'h0;
         own_lo_r   <= 3'h0;
         rw_r       <= 1'b0;
         acked_r    <= 1'b0;
         msb_next_r <= 1'b1;
         nack_r     <= 1'b0;
         reading_r  <= 1'b0;
         in_frame_r <= 1'b0;
         hs_l_r     <= 1'b0;
         ptr_l_r    <= tws_pkg::PTR_RESET;
         ptr_tgl_r  <= 1'b0;
         wr_l_r     <= '0;
         wr_tgl_r   <= 1'b0;
         rd_tgl_r   <= 1'b0;
         sda_oe     <= 1'b0;
      end else if (to_hit) begin
         // (R17) timeout: release data, wait for next start
         state_r    <= tws_pkg::TWS_IDLE;
         sda_oe     <= 1'b0;
         in_frame_r <= 1'b0;
         if (reading_r) begin
            rd_tgl_r <= ~rd_tgl_r;
         end
         reading_r  <= 1'b0;
      end else if (start_det) begin
         // (R19) repeated start ends the running transaction
         state_r    <= tws_pkg::TWS_RECV;
         kind_r     <= tws_pkg::TWS_K_ADDR;
         cnt_r      <= 4'h0;
         sda_oe     <= 1'b0;
         in_frame_r <= 1'b1;
         // (R21) pins latched at each start
         own_lo_r   <= {pin2_s_r[1], pin1_s_r[1], pin0_s_r[1]};
         // (R10) start ends a read
         if (reading_r) begin
            rd_tgl_r <= ~rd_tgl_r;
         end
         reading_r  <= 1'b0;
      end else if (stop_det) begin
         state_r    <= tws_pkg::TWS_IDLE;
         sda_oe     <= 1'b0;
         in_frame_r <= 1'b0;
         // (R15) stop restores fast mode
         hs_l_r     <= 1'b0;
         // (R23) read access completes at stop
         if (reading_r) begin
            rd_tgl_r <= ~rd_tgl_r;
         end
         reading_r  <= 1'b0;
      end else begin
         case (state_r)
            tws_pkg::TWS_RECV: begin
               // (R24) shift in msb first
               if (scl_rise) begin
                  rx_r  <= {rx_r[6:0], sda_s_r[1]};
                  cnt_r <= cnt_r + 4'h1;
               end else if (scl_fall && cnt_r == tws_pkg::BITS_BYTE) begin
                  acked_r <= 1'b0;
                  state_r <= tws_pkg::TWS_ACK;
                  case (kind_r)
                     tws_pkg::TWS_K_ADDR: begin
                        if (own_match) begin
                           // (R6) (R9) own address acknowledged
                           sda_oe     <= 1'b1;
                           acked_r    <= 1'b1;
                           rw_r       <= rx_r[0];
                           reading_r  <= rx_r[0];
                           kind_r     <= tws_pkg::TWS_K_PTR;
                           msb_next_r <= 1'b1;
                        end else if (rx_r[7:3] == tws_pkg::HS_CODE) begin
                           // (R13) (R14) code byte: no ack, high speed
                           hs_l_r  <= 1'b1;
                           state_r <= tws_pkg::TWS_IDLE;
                        end else begin
                           // (R25) foreign address ignored till start
                           state_r <= tws_pkg::TWS_IDLE;
                        end
                     end
                     tws_pkg::TWS_K_PTR: begin
                        // (R1) (R22) pointer byte, low three bits
                        ptr_l_r    <= rx_r[2:0];
                        ptr_tgl_r  <= ~ptr_tgl_r;
                        sda_oe     <= 1'b1;
                        acked_r    <= 1'b1;
                        kind_r     <= tws_pkg::TWS_K_DATA;
                        msb_next_r <= 1'b1;
                     end
                     default: begin
                        // (R7) (R8) data byte, high byte first
                        wr_l_r     <= '{ptr: ptr_l_r, msb_byte: msb_next_r,
                                        data: rx_r};
                        wr_tgl_r   <= ~wr_tgl_r;
                        sda_oe     <= 1'b1;
                        acked_r    <= 1'b1;
                        msb_next_r <= 1'b0;
                     end
                  endcase
               end
            end
            tws_pkg::TWS_ACK: begin
               // (R20) ack held through the ninth high phase
               if (scl_fall) begin
                  cnt_r <= 4'h0;
                  if (!acked_r) begin
                     sda_oe  <= 1'b0;
                     state_r <= tws_pkg::TWS_IDLE;
                  end else if (rw_r) begin
                     // (R2) (R4) (R5) high byte of stored-pointer word
                     tx_r       <= {word_l_r[14:8], 1'b0};
                     sda_oe     <= ~word_l_r[15];
                     cnt_r      <= 4'h1;
                     msb_next_r <= 1'b0;
                     state_r    <= tws_pkg::TWS_SEND;
                  end else begin
                     sda_oe  <= 1'b0;
                     state_r <= tws_pkg::TWS_RECV;
                  end
               end
            end
            tws_pkg::TWS_SEND: begin
               // (R24) shift out msb first
               if (scl_fall) begin
                  if (cnt_r == tws_pkg::BITS_BYTE) begin
                     sda_oe  <= 1'b0;
                     state_r <= tws_pkg::TWS_MACK;
                  end else begin
                     sda_oe <= ~tx_r[7];
                     tx_r   <= {tx_r[6:0], 1'b0};
                     cnt_r  <= cnt_r + 4'h1;
                  end
               end
            end
            tws_pkg::TWS_MACK: begin
               if (scl_rise) begin
                  nack_r <= sda_s_r[1];
               end else if (scl_fall) begin
                  if (nack_r) begin
                     // (R10) (R11) nack ends read, line released
                     sda_oe    <= 1'b0;
                     state_r   <= tws_pkg::TWS_IDLE;
                     rd_tgl_r  <= ~rd_tgl_r;
                     reading_r <= 1'b0;
                  end else begin
                     // (R5) low byte after high byte
                     tx_r    <= {word_l_r[6:0], 1'b0};
                     sda_oe  <= ~word_l_r[7];
                     cnt_r   <= 4'h1;
                     state_r <= tws_pkg::TWS_SEND;
                  end
               end
            end
            default: begin
               sda_oe <= 1'b0;
            end
         endcase
      end
   end

   // ---------------- core domain ----------------
   logic [2:0]          ptr_tgl_s_r;
   logic [2:0]          wr_tgl_s_r;
   logic [2:0]          rd_tgl_s_r;
   logic [1:0]          hs_s_r;
   logic [1:0]          frame_s_r;
   logic [1:0]          scl_c_r;
   logic [1:0]          sda_c_r;
   logic [1:0]          snap_ack_s_r;
   logic [31:0]         to_cnt_r;

   // synchronisers for link-side toggles, levels and pins
   always_ff @(posedge ref_clk) begin
      ptr_tgl_s_r  <= {ptr_tgl_s_r[1:0], ptr_tgl_r};
      wr_tgl_s_r   <= {wr_tgl_s_r[1:0], wr_tgl_r};
      rd_tgl_s_r   <= {rd_tgl_s_r[1:0], rd_tgl_r};
      hs_s_r       <= {hs_s_r[0], hs_l_r};
      frame_s_r    <= {frame_s_r[0], in_frame_r};
      scl_c_r      <= {scl_c_r[0], scl_in};
      sda_c_r      <= {sda_c_r[0], sda_in};
      snap_ack_s_r <= {snap_ack_s_r[0], snap_ack_r};
   end

   // pointer and write events presented to the register set
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         pointer_sel <= tws_pkg::PTR_RESET;
         wr_valid    <= 1'b0;
         wr_evt      <= '0;
         rd_access   <= 1'b0;
         hs_mode     <= 1'b0;
      end else begin
         // (R4) pointer changes only on a pointer byte
         if (ptr_tgl_s_r[2] != ptr_tgl_s_r[1]) begin
            pointer_sel <= ptr_l_r;
         end
         // (R7) write strobe carrying byte and half
         wr_valid <= wr_tgl_s_r[2] != wr_tgl_s_r[1];
         if (wr_tgl_s_r[2] != wr_tgl_s_r[1]) begin
            wr_evt <= wr_l_r;
         end
         // (R23) one pulse per completed read
         rd_access <= rd_tgl_s_r[2] != rd_tgl_s_r[1];
         // (R14) (R15) filter speed select
         hs_mode   <= hs_s_r[1];
      end
   end

   // read word offered to the link side whenever the last one was taken
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         snap_req_r <= 1'b0;
         snap_r     <= tws_pkg::WORD_RESET;
      end else if (snap_req_r == snap_ack_s_r[1]) begin
         snap_r     <= reg_rd_data;
         snap_req_r <= ~snap_req_r;
      end
   end

   // (R16) low-line timeout inside a frame
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         to_cnt_r     <= 32'h0000_0000;
         bus_to_tgl_r <= 1'b0;
         bus_timeout  <= 1'b0;
      end else begin
         bus_timeout <= 1'b0;
         if (!frame_s_r[1] || (scl_c_r[1] && sda_c_r[1])) begin
            to_cnt_r <= 32'h0000_0000;
         end else if (to_cnt_r >= TIMEOUT_CYCLES - 1) begin
            to_cnt_r     <= 32'h0000_0000;
            bus_to_tgl_r <= ~bus_to_tgl_r;
            bus_timeout  <= 1'b1;
         end else begin
            to_cnt_r <= to_cnt_r + 32'h0000_0001;
         end
      end
   end

   // data pin only ever pulls low
   always_ff @(posedge ref_clk) begin
      sda_out <= 1'b0;
   end

endmodule

// File: testbench/tws_slave_props.sv
`timescale 1ns/1ps
module tws_slave_props #(
   parameter int unsigned TIMEOUT_CYCLES = 1000
) (
   input wire logic             ref_clk,
   input wire logic             reset_n,
   input wire logic             link_clk,
   input wire logic             scl_in,
   input wire logic             sda_in,
   input wire logic             sda_out,
   input wire logic             sda_oe,
   input wire logic [2:0]       pointer_sel,
   input wire logic             wr_valid,
   input wire tws_pkg::tws_wr_t wr_evt,
   input wire logic             rd_access,
   input wire logic             hs_mode,
   input wire logic             bus_timeout
);
   int unsigned low_cnt;
   logic        sda_d;
   // time either line has been low, and last data level for stop detect
   always_ff @(posedge ref_clk) begin
      sda_d <= sda_in;
      if (!reset_n || (scl_in && sda_in)) begin
         low_cnt <= 0;
      end else begin
         low_cnt <= low_cnt + 1;
      end
   end

   out_low_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !sda_out) else $error("data output not low");
   ack_hold_a: assert property (@(posedge link_clk) disable iff (!reset_n)
      (scl_in && sda_oe) |=> (sda_oe || !scl_in)) else $error("data released in clock high");
   wr_pulse_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      wr_valid |=> !wr_valid) else $error("write strobe too long");
   wr_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !wr_valid |=> $stable(wr_evt) || wr_valid) else $error("write word moved");
   rd_pulse_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      rd_access |=> !rd_access) else $error("read event too long");
   tmo_pulse_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      bus_timeout |=> !bus_timeout) else $error("timeout pulse too long");
   tmo_cause_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      bus_timeout |-> low_cnt + 4 >= TIMEOUT_CYCLES) else $error("timeout too early");
   tmo_release_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      bus_timeout |-> ##[0:8] !sda_oe) else $error("data held after timeout");
   hs_stop_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (scl_in && sda_in && !sda_d) |-> ##[1:8] !hs_mode) else $error("fast mode not back");
   reset_clear_a: assert property (@(posedge ref_clk)
      !reset_n |=> pointer_sel == 3'h0) else $error("pointer not cleared");

   // main scenarios reached
   c_write: cover property (@(posedge ref_clk) wr_valid);
   c_read: cover property (@(posedge ref_clk) rd_access);
   c_hs: cover property (@(posedge ref_clk) $rose(hs_mode));
   c_tmo: cover property (@(posedge ref_clk) bus_timeout);
endmodule
bind tws_slave tws_slave_props #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_props (
   .ref_clk(ref_clk), .reset_n(reset_n), .link_clk(link_clk), .scl_in(scl_in),
   .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .pointer_sel(pointer_sel),
   .wr_valid(wr_valid), .wr_evt(wr_evt), .rd_access(rd_access), .hs_mode(hs_mode),
   .bus_timeout(bus_timeout));

// File: testbench/tws_mst_model.sv
`timescale 1ns/1ps
module tws_mst_model (
   output logic      scl,
   output logic      sda_pull,
   input  wire logic sda
);
   // bus idles with both lines released
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   // one 600 ns bit: data set mid low, read mid high
   task automatic bit_io(input logic b, output logic r);
      #150 sda_pull = !b;
      #150 scl = 1'b1;
      #150 r = sda;
      #150 scl = 1'b0;
   endtask
   // start, also repeated start from a low clock
   task automatic start();
      #150 sda_pull = 1'b0;
      #150 scl = 1'b1;
      #300 sda_pull = 1'b1;
      #300 scl = 1'b0;
   endtask
   task automatic stop();
      #150 sda_pull = 1'b1;
      #150 scl = 1'b1;
      #300 sda_pull = 1'b0;
      #300;
   endtask
   // msb first, slave ack read in ninth slot
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = !r;
   endtask
   // ack, or leave data high on the last byte
   task automatic rd_byte(input logic mack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(!mack, r);
   endtask
endmodule

// File: testbench/tws_slave_test.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
   $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module tws_slave_test;
   localparam int unsigned TMO = 1000;
   logic             ref_clk, reset_n, link_clk, scl, m_pull, sda, sda_out, sda_oe, ack;
   logic             wr_valid, rd_access, hs_mode, bus_timeout;
   logic [2:0]       pins, pointer_sel;
   logic [7:0]       b0, b1;
   logic [15:0]      reg_rd_data;
   tws_pkg::tws_wr_t wr_evt;
   tws_pkg::tws_wr_t wq[$];
   int               fails, n_checks, n_rd, n_tmo;

   // open-drain data wire with pull-up; register set tags word with pointer
   assign sda = m_pull ? 1'b0 : (sda_oe ? sda_out : 1'b1);
   assign reg_rd_data = {5'h18, pointer_sel, 5'h0A, pointer_sel};
   // clocks
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = !ref_clk;
   end
   initial begin
      link_clk = 1'b0;
      #3.3;
      forever #7.5 link_clk = !link_clk;
   end
   // collect pulses where outputs are settled
   always @(negedge ref_clk) begin
      if (wr_valid === 1'b1) wq.push_back(wr_evt);
      if (rd_access === 1'b1) n_rd++;
      if (bus_timeout === 1'b1) n_tmo++;
   end

   tws_mst_model i_mst (.scl(scl), .sda_pull(m_pull), .sda(sda));
   tws_slave #(.TIMEOUT_CYCLES(TMO)) i_dut (
      .ref_clk(ref_clk), .reset_n(reset_n), .link_clk(link_clk), .scl_in(scl),
      .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .addr_pin_bit0(pins[0]),
      .addr_pin_bit1(pins[1]), .addr_pin_bit2(pins[2]), .pointer_sel(pointer_sel),
      .reg_rd_data(reg_rd_data), .wr_valid(wr_valid), .wr_evt(wr_evt),
      .rd_access(rd_access), .hs_mode(hs_mode), .bus_timeout(bus_timeout));

   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // address and pointer byte of a write
   task automatic put_ptr(input logic [7:0] p);
      i_mst.start();
      i_mst.wr_byte({tws_pkg::ADDR_UPPER, pins, 1'b0}, ack);
      `CHK("address ack", 1'b1, ack)
      i_mst.wr_byte(p, ack);
      `CHK("pointer ack", 1'b1, ack)
   endtask
   // two-byte read of the word behind pointer p
   task automatic get_word(input logic [2:0] p);
      int n0;
      n0 = n_rd;
      i_mst.start();
      i_mst.wr_byte({tws_pkg::ADDR_UPPER, pins, 1'b1}, ack);
      `CHK("read address ack", 1'b1, ack)
      i_mst.rd_byte(1'b1, b0);
      i_mst.rd_byte(1'b0, b1);
      `CHK("high byte", {5'h18, p}, b0)
      `CHK("low byte", {5'h0A, p}, b1)
      #100 `CHK("released after nack", 1'b0, sda_oe)
      i_mst.stop();
      repeat (10) @(posedge ref_clk);
      `CHK("read event", n0 + 1, n_rd)
   endtask
   task automatic t_write();
      put_ptr(8'hFB);
      i_mst.wr_byte(8'hA5, ack);
      `CHK("data ack", 1'b1, ack)
      i_mst.wr_byte(8'h3C, ack);
      i_mst.stop();
      repeat (10) @(posedge ref_clk);
      `CHK("pointer", 3'h3, pointer_sel)
      `CHK("write count", 2, wq.size())
      `CHK("first write", {3'h3, 1'b1, 8'hA5}, wq[0])
      `CHK("second write", {3'h3, 1'b0, 8'h3C}, wq[1])
      $display("write test done");
   endtask
   task automatic t_single();
      wq.delete();
      put_ptr(8'h01);
      get_word(3'h1);
      put_ptr(8'h02);
      i_mst.wr_byte(8'h77, ack);
      get_word(3'h2);
      get_word(3'h2);
      `CHK("single write", 1, wq.size())
      `CHK("high only", {3'h2, 1'b1, 8'h77}, wq[0])
      $display("single byte test done");
   endtask
   task automatic t_foreign();
      wq.delete();
      i_mst.start();
      i_mst.wr_byte({tws_pkg::ADDR_UPPER, ~pins, 1'b0}, ack);
      `CHK("foreign address", 1'b0, ack)
      i_mst.wr_byte(8'h01, ack);
      `CHK("ignored byte", 1'b0, ack)
      i_mst.stop();
      repeat (10) @(posedge ref_clk);
      `CHK("no write", 0, wq.size())
      `CHK("pointer kept", 3'h2, pointer_sel)
      $display("foreign address test done");
   endtask
   task automatic t_hs();
      @(posedge ref_clk);
      #1 pins = 3'h2;
      for (int k = 0; k < 8; k++) begin
         i_mst.start();
         i_mst.wr_byte({tws_pkg::HS_CODE, k[2:0]}, ack);
         `CHK("code not acked", 1'b0, ack)
         repeat (10) @(posedge ref_clk);
         `CHK("high speed on", 1'b1, hs_mode)
         if (k == 7) put_ptr(8'h00);
         i_mst.stop();
         repeat (10) @(posedge ref_clk);
         `CHK("fast mode again", 1'b0, hs_mode)
      end
      `CHK("new pins pointer", 3'h0, pointer_sel)
      $display("high speed test done");
   endtask
   task automatic t_timeout();
      int   n0;
      logic r;
      n0 = n_rd;
      i_mst.start();
      i_mst.wr_byte({tws_pkg::ADDR_UPPER, pins, 1'b1}, ack);
      i_mst.bit_io(1'b1, r);
      i_mst.bit_io(1'b1, r);
      #200 `CHK("driving zero bit", 1'b1, sda_oe)
      #(TMO * 120);
      `CHK("timeout fired", 1, n_tmo)
      `CHK("line released", 1'b0, sda_oe)
      `CHK("open read closed", n0 + 1, n_rd)
      i_mst.wr_byte({tws_pkg::ADDR_UPPER, pins, 1'b0}, ack);
      `CHK("no ack before start", 1'b0, ack)
      get_word(3'h0);
      $display("timeout test done");
   endtask

   initial begin
      reset_n = 1'b0;
      pins = 3'h5;
      repeat (5) @(posedge ref_clk);
      #1 reset_n = 1'b1;
      repeat (5) @(posedge ref_clk);
      `CHK("reset pointer", tws_pkg::PTR_RESET, pointer_sel)
      t_write();
      t_single();
      t_foreign();
      t_hs();
      t_timeout();
      end_sim();
   end
   // watchdog well beyond the expected third of a millisecond
   initial begin
      #2000000;
      fails++;
      end_sim();
   end
endmodule
